// ### src/isr_cfg.svh
// Constants for the slave address receiver
`ifndef ISR_CFG_SVH
`define ISR_CFG_SVH
`define ISR_MODE_7B 2'h0
`define ISR_MODE_10B 2'h1
`define ISR_MODE_7B_SP 2'h2
`define ISR_MODE_10B_SP 2'h3
`define ISR_HI10_TAG 5'h1E
`define ISR_BITS_PER_BYTE 4'h8
`define ISR_BIT_ZERO 4'h0
`define ISR_FIFO_WIDTH 8
`define ISR_FIFO_DEPTH 32
`endif

// ### src/isr_pkg.sv
// Types shared by the slave address receiver
package isr_pkg;
  // Software control bits grouped together
  typedef struct packed {
    logic [1:0] port_mode_select;
    logic start_irq_enable;
    logic stop_irq_enable;
    logic address_hold_enable;
    logic data_hold_enable;
    logic stretch_enable;
    logic buffer_overwrite_enable;
    logic ack_value_out;
  } isr_ctrl_t;
  // Status bits presented to software
  typedef struct packed {
    logic start_seen_flag;
    logic stop_seen_flag;
    logic rw_status;
    logic data_not_address;
    logic buffer_full_flag;
    logic receive_overflow_flag;
    logic ack_time_flag;
    logic address_update_flag;
    logic ack_received_status;
    logic port_irq_flag;
  } isr_stat_t;
  typedef enum logic [2:0] {
    ISR_IDLE, ISR_SHIFT, ISR_ACK_HOLD, ISR_ACK, ISR_STRETCH, ISR_IGNORE
  } isr_state_t;
endpackage

// ### src/isr_fifo.sv
// Receive FIFO with valid/ready on both sides
`timescale 1ns/10ps
module isr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;
  logic full;
  logic empty;
  assign empty = (wp_r == rp_r);
  assign full = (wp_r[AW-1:0] == rp_r[AW-1:0]) && (wp_r[AW] != rp_r[AW]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rp_r[AW-1:0]];
  // Storage written only when space exists
  always_ff @(posedge clk)
  begin
    if (in_valid && !full)
      mem[wp_r[AW-1:0]] <= in_data;
  end
  // Pointers carry an extra wrap bit to tell full from empty
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_r <= '0;
      rp_r <= '0;
    end
    else
    begin
      if (in_valid && !full)
        wp_r <= wp_r + 1'b1;
      if (out_ready && !empty)
        rp_r <= rp_r + 1'b1;
    end
  end
endmodule // isr_fifo

// ### src/isr_slave.sv
// I2C slave receive side: address match, acknowledge, stretching, flags
`timescale 1ns/10ps
`include "isr_cfg.svh"
module isr_slave
  import isr_pkg::*;
#(
  parameter int FIFO_WIDTH = `ISR_FIFO_WIDTH,
  parameter int FIFO_DEPTH = `ISR_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire isr_ctrl_t ctrl,
  input wire logic [7:0] own_address_reg,
  input wire logic own_address_wr,
  input wire logic clock_release,
  input wire logic irq_flag_clear,
  input wire logic overflow_clear,
  input wire logic start_flag_clear,
  input wire logic stop_flag_clear,
  input wire logic buffer_read,
  output logic [7:0] rx_tx_buffer,
  output isr_stat_t status,
  output logic clock_held,
  output logic fifo_valid,
  input wire logic fifo_ready,
  output logic [FIFO_WIDTH-1:0] fifo_data
);
  logic rst_a_r;
  logic rst_n_r;
  logic scl_m_r;
  logic scl_s_r;
  logic scl_d_r;
  logic sda_m_r;
  logic sda_s_r;
  logic sda_d_r;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic low_seen_r;
  isr_state_t state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic first_byte_r;
  logic low_byte_r;
  logic prior_match_r;
  logic ack_drive_r;
  logic hold_r;
  logic ua_pend_r;
  logic is_10b;
  logic sp_mode;
  logic hold_en;
  logic overflow;
  logic match7;
  logic match10h;
  logic byte_done;
  logic addr_ok;
  logic f_in_ready;
  logic f_out_valid;
  logic [FIFO_WIDTH-1:0] f_out_data;
  logic byte_push_r;
  // Reset release through two flops
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_a_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_a_r <= 1'b1;
      rst_n_r <= rst_a_r;
    end
  end
  // Bus pins pass two flops; the third stage feeds edge detection only
  always_ff @(posedge sys_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_m_r <= scl_in;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= sda_in;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
    end
  end
  assign scl_rise = scl_s_r && !scl_d_r;
  assign scl_fall = !scl_s_r && scl_d_r;
  assign start_det = scl_s_r && scl_d_r && !sda_s_r && sda_d_r;
  // stop needs a prior SCL low
  assign stop_det = scl_s_r && scl_d_r && sda_s_r && !sda_d_r && low_seen_r;
  assign is_10b = (ctrl.port_mode_select == `ISR_MODE_10B) ||
                  (ctrl.port_mode_select == `ISR_MODE_10B_SP);
  assign sp_mode = (ctrl.port_mode_select == `ISR_MODE_7B_SP) ||
                   (ctrl.port_mode_select == `ISR_MODE_10B_SP);
  assign hold_en = ctrl.address_hold_enable || ctrl.data_hold_enable;
  // overflow condition; a full FIFO refuses bytes as a full buffer does
  assign overflow = status.buffer_full_flag || !f_in_ready ||
                    (status.receive_overflow_flag && !ctrl.buffer_overwrite_enable);
  assign match7 = (shift_r[7:1] == own_address_reg[7:1]);
  assign match10h = (shift_r[7:3] == `ISR_HI10_TAG) && (shift_r[2:1] == own_address_reg[2:1]);
  assign byte_done = scl_fall && (bit_cnt_r == `ISR_BITS_PER_BYTE);
  // a first byte that fails either address test raises no flag
  assign addr_ok = !first_byte_r || ((is_10b ? match10h : match7) &&
                   !(is_10b && shift_r[0] && !prior_match_r));
  // SCL low seen since last start, qualifies stops
  always_ff @(posedge sys_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      low_seen_r <= 1'b0;
    else if (start_det)
      low_seen_r <= 1'b0;
    else if (!scl_s_r)
      low_seen_r <= 1'b1;
  end
  // Main receive state machine
  always_ff @(posedge sys_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      state_r <= ISR_IDLE;
      bit_cnt_r <= `ISR_BIT_ZERO;
      shift_r <= 8'h00;
      first_byte_r <= 1'b0;
      low_byte_r <= 1'b0;
      prior_match_r <= 1'b0;
      ack_drive_r <= 1'b0;
      hold_r <= 1'b0;
      ua_pend_r <= 1'b0;
      byte_push_r <= 1'b0;
    end
    else
    begin
      byte_push_r <= 1'b0;
      if (start_det)
      begin
        // Restart has the same effect as start
        state_r <= ISR_SHIFT;
        bit_cnt_r <= `ISR_BIT_ZERO;
        first_byte_r <= 1'b1;
        low_byte_r <= 1'b0;
        ack_drive_r <= 1'b0;
        hold_r <= 1'b0;
      end
      else if (stop_det)
      begin
        state_r <= ISR_IDLE;
        prior_match_r <= 1'b0;
        ack_drive_r <= 1'b0;
        hold_r <= 1'b0;
      end
      else
      begin
        case (state_r)
          ISR_SHIFT:
          begin
            // MSB first; sample on rising SCL
            if (scl_rise)
            begin
              shift_r <= {shift_r[6:0], sda_s_r};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
            else if (byte_done)
            begin
              bit_cnt_r <= `ISR_BIT_ZERO;
              if (first_byte_r && !(is_10b ? match10h : match7))
                state_r <= ISR_IGNORE;
              // 10-bit read needs prior full match
              else if (first_byte_r && is_10b && shift_r[0] && !prior_match_r)
                state_r <= ISR_IGNORE;
              else
              begin
                byte_push_r <= !overflow && !(low_byte_r);
                if (hold_en)
                begin
                  // stall at ack time for software
                  hold_r <= 1'b1;
                  state_r <= ISR_ACK_HOLD;
                end
                else
                begin
                  ack_drive_r <= !overflow;
                  state_r <= ISR_ACK;
                end
              end
            end
          end
          ISR_ACK_HOLD:
          begin
            if (clock_release)
            begin
              hold_r <= 1'b0;
              ack_drive_r <= !ctrl.ack_value_out && !overflow;
              state_r <= ISR_ACK;
            end
          end
          ISR_ACK:
          begin
            // ninth pulse ends on falling SCL
            if (scl_fall)
            begin
              ack_drive_r <= 1'b0;
              // low byte needs full 8-bit match
              if (low_byte_r)
                prior_match_r <= (shift_r == own_address_reg);
              if (is_10b && first_byte_r && !shift_r[0] && ack_drive_r)
              begin
                // hold SCL for low address update
                hold_r <= 1'b1;
                ua_pend_r <= 1'b1;
                low_byte_r <= 1'b1;
                state_r <= ISR_STRETCH;
              end
              else if (low_byte_r)
              begin
                hold_r <= 1'b1;
                ua_pend_r <= 1'b1;
                low_byte_r <= 1'b0;
                state_r <= ISR_STRETCH;
              end
              else if (ctrl.stretch_enable && ack_drive_r)
              begin
                hold_r <= 1'b1;
                state_r <= ISR_STRETCH;
              end
              else
                state_r <= ack_drive_r ? ISR_SHIFT : ISR_IGNORE;
              first_byte_r <= 1'b0;
            end
          end
          ISR_STRETCH:
          begin
            if (ua_pend_r ? own_address_wr : clock_release)
            begin
              hold_r <= 1'b0;
              ua_pend_r <= 1'b0;
              state_r <= ISR_SHIFT;
            end
          end
          default:
            state_r <= state_r;
        endcase
      end
    end
  end
  // Status flags; hardware set wins over software clear
  always_ff @(posedge sys_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      status <= '0;
    else
    begin
      if (start_det)
        status.start_seen_flag <= 1'b1;
      else if (stop_det || start_flag_clear)
        status.start_seen_flag <= 1'b0;
      if (stop_det)
        status.stop_seen_flag <= 1'b1;
      else if (start_det || stop_flag_clear)
        status.stop_seen_flag <= 1'b0;
      if (state_r == ISR_SHIFT && byte_done && first_byte_r && addr_ok)
        status.rw_status <= shift_r[0];
      if (state_r == ISR_SHIFT && byte_done && addr_ok)
        status.data_not_address <= !first_byte_r && !low_byte_r;
      if (byte_push_r)
        status.buffer_full_flag <= 1'b1;
      else if (buffer_read)
        status.buffer_full_flag <= 1'b0;
      if (state_r == ISR_SHIFT && byte_done && overflow && !first_byte_r)
        status.receive_overflow_flag <= 1'b1;
      else if (overflow_clear)
        status.receive_overflow_flag <= 1'b0;
      // ack time flag only in hold modes
      if (state_r == ISR_SHIFT && byte_done && hold_en && addr_ok)
        status.ack_time_flag <= 1'b1;
      else if (scl_fall && state_r == ISR_ACK)
        status.ack_time_flag <= 1'b0;
      // update flag cleared by address rewrite
      if (state_r == ISR_ACK && scl_fall && (low_byte_r ||
          (is_10b && first_byte_r && !shift_r[0] && ack_drive_r)))
        status.address_update_flag <= 1'b1;
      else if (own_address_wr)
        status.address_update_flag <= 1'b0;
      // acknowledge level sampled on ninth rise
      if (state_r == ISR_ACK && scl_rise)
        status.ack_received_status <= sda_s_r;
      if ((state_r == ISR_ACK && scl_fall && (ack_drive_r || low_byte_r)) ||
          (state_r == ISR_SHIFT && byte_done && hold_en && !overflow && addr_ok) ||
          ((start_det || stop_det) && sp_mode) ||
          (start_det && ctrl.start_irq_enable && !sp_mode) ||
          (stop_det && ctrl.stop_irq_enable && !sp_mode))
        status.port_irq_flag <= 1'b1;
      else if (irq_flag_clear)
        status.port_irq_flag <= 1'b0;
    end
  end
  // Buffer register and pin drivers; pins only ever pull low
  always_ff @(posedge sys_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      rx_tx_buffer <= 8'h00;
      scl_out <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
      clock_held <= 1'b0;
      fifo_valid <= 1'b0;
      fifo_data <= '0;
    end
    else
    begin
      if (byte_push_r)
        rx_tx_buffer <= shift_r;
      scl_oe_n <= !hold_r;
      clock_held <= hold_r;
      // drive SDA low during the acknowledge slot
      sda_oe_n <= !(ack_drive_r && state_r == ISR_ACK);
      if (fifo_valid && fifo_ready)
        fifo_valid <= 1'b0;
      else if (fifo_ready && f_out_valid)
        fifo_valid <= 1'b1;
      if (fifo_ready && !fifo_valid)
        fifo_data <= f_out_data; // Loads together with the FIFO pop
    end
  end
  // FIFO stream copy of accepted bytes; a full FIFO drops nothing silently
  isr_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(sys_clk),
    .rst_n(rst_n_r),
    .in_valid(byte_push_r),
    .in_ready(f_in_ready),
    .in_data(shift_r),
    .out_valid(f_out_valid),
    .out_ready(fifo_ready && !fifo_valid),
    .out_data(f_out_data)
  );
endmodule // isr_slave

// ### bench/isr_slave_monitor.sv
// Port checker for the slave receiver, bound into every slave instance
`timescale 1ns/10ps
module isr_slave_mon
  import isr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe_n,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire isr_ctrl_t ctrl,
  input wire logic own_address_wr,
  input wire logic clock_release,
  input wire isr_stat_t status,
  input wire logic clock_held
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic hold;
  // Both hold enables hand the acknowledge to software
  assign hold = ctrl.address_hold_enable && ctrl.data_hold_enable;
  pin_low_a:
    assert property (!scl_out && !sda_out) else $error("pin data not low");
  start_flag_a:
    assert property ($fell(sda_in) && scl_in && $past(scl_in) |-> ##[1:6] status.start_seen_flag)
    else $error("start not flagged");
  stop_flag_a:
    assert property ($rose(sda_in) && scl_in && $past(scl_in) |-> ##[1:6] status.stop_seen_flag)
    else $error("stop not flagged");
  sda_edge_a:
    assert property ($changed(sda_oe_n) |-> !scl_in) else $error("data moved with clock high");
  sw_ack_a:
    assert property (hold && ctrl.ack_value_out |-> sda_oe_n) else $error("ack value ignored");
  hw_irq_a:
    assert property ($rose(sda_oe_n) && !ctrl.address_hold_enable && !ctrl.data_hold_enable
      |-> ##[0:3] status.port_irq_flag) else $error("no irq on ack");
  scl_hold_a:
    assert property ($rose(clock_held) |-> ##[0:2] !scl_oe_n) else $error("clock not held");
  release_a:
    assert property (clock_held && clock_release && !status.address_update_flag
      |-> ##[1:4] scl_oe_n) else $error("clock not released");
  ua_clear_a:
    assert property (status.address_update_flag && own_address_wr
      |-> ##[1:3] !status.address_update_flag) else $error("update flag stuck");
  start_irq_a:
    assert property ($rose(status.start_seen_flag) && (ctrl.start_irq_enable
      || ctrl.port_mode_select[1]) |-> ##[0:2] status.port_irq_flag)
    else $error("start irq missing");
  cover property ($rose(status.address_update_flag));
  cover property (hold && $rose(clock_held));
  cover property ($rose(status.stop_seen_flag));
endmodule // isr_slave_mon
bind isr_slave isr_slave_mon mon (.*);

// ### bench/isr_master_model.sv
// Bus master model driving the open-drain clock and data lines
`timescale 1ns/10ps
module isr_master (
  input wire logic clk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_d,
  output logic sda_d
);
  // Idle bus: both lines released to the pull-ups
  initial
  begin
    scl_d = 1'h1;
    sda_d = 1'h1;
  end
  task automatic hc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Release clock; a stretching slave keeps it low meanwhile
  task automatic hi();
    scl_d <= 1'h1;
    @(posedge clk);
    wait (scl);
    hc(2);
  endtask
  task automatic start();
    sda_d <= 1'h1;
    hc(2);
    hi();
    sda_d <= 1'h0;
    hc(3);
    scl_d <= 1'h0;
    hc(2);
  endtask
  task automatic stop();
    sda_d <= 1'h0;
    hc(3);
    hi();
    sda_d <= 1'h1;
    hc(4);
  endtask
  task automatic bit1(input logic b, output logic s);
    sda_d <= b;
    hc(3);
    hi();
    s = sda;
    scl_d <= 1'h0;
    hc(2);
  endtask
  task automatic bits8(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit1(d[i], s);
  endtask
  task automatic ack(output logic a);
    bit1(1'h1, a);
  endtask
endmodule // isr_master

// ### bench/testbench.sv
// Self-checking bench for the slave address receiver
`timescale 1ns/10ps
module testbench;
  import isr_pkg::*;
  logic sys_clk, resetn, scl_out, scl_oe_n, sda_out, sda_oe_n, scl_d, sda_d, scl_w, sda_w, a;
  logic own_address_wr, clock_release, irq_flag_clear, overflow_clear, start_flag_clear;
  logic stop_flag_clear, buffer_read, clock_held, fifo_valid, fifo_ready;
  logic [7:0] own_address_reg, rx_tx_buffer, fifo_data;
  isr_ctrl_t ctrl;
  isr_stat_t status;
  int err_total, n_tests, cyc, cnt;
  // Open-drain wires with pull-ups
  assign scl_w = scl_d & (scl_oe_n | scl_out);
  assign sda_w = sda_d & (sda_oe_n | sda_out);
  isr_slave dut (.scl_in(scl_w), .sda_in(sda_w), .*);
  isr_master m (.clk(sys_clk), .scl(scl_w), .sda(sda_w), .*);
  initial
  begin
    sys_clk = 1'h0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic hc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e)
    begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // Software strobes: 0 clears flags, 1 reads buffer, 2 releases, 3 rewrites address
  task automatic pls(input int w);
    @(posedge sys_clk);
    case (w)
      0: {irq_flag_clear, overflow_clear, start_flag_clear, stop_flag_clear} <= 4'hF;
      1: buffer_read <= 1'h1;
      2: clock_release <= 1'h1;
      default: own_address_wr <= 1'h1;
    endcase
    @(posedge sys_clk);
    {irq_flag_clear, overflow_clear, start_flag_clear, stop_flag_clear} <= 4'h0;
    {buffer_read, clock_release, own_address_wr} <= 3'h0;
    hc(2);
  endtask
  task automatic xfer(input logic [7:0] d, input logic e);
    m.bits8(d);
    m.ack(a);
    chk(a, e);
    // Let the ninth falling edge reach the flags before anyone looks
    hc(3);
    if (!e)
      chk(status.ack_received_status, 1'h0);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Cuts a hung run short
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      end_sim();
    end
  end
  initial
  begin
    {resetn, own_address_wr, clock_release, irq_flag_clear, overflow_clear} = 5'h0;
    {start_flag_clear, stop_flag_clear, buffer_read, fifo_ready} = 4'h0;
    ctrl = 9'h000;
    own_address_reg = 8'hA5;
    hc(20);
    resetn <= 1'h1;
    hc(5);
    chk(sda_oe_n, 1'h1);
    // Plain 7-bit write, then a byte refused while the buffer is full
    m.start();
    hc(4);
    chk(status.start_seen_flag, 1'h1);
    chk(status.port_irq_flag, 1'h0);
    xfer(8'hA4, 1'h0);
    chk(rx_tx_buffer, 8'hA4);
    chk(status.rw_status, 1'h0);
    chk(status.port_irq_flag, 1'h1);
    pls(1);
    chk(status.buffer_full_flag, 1'h0);
    xfer(8'h3C, 1'h0);
    chk(rx_tx_buffer, 8'h3C);
    chk(status.data_not_address, 1'h1);
    xfer(8'hC3, 1'h1);
    chk(status.receive_overflow_flag, 1'h1);
    m.stop();
    hc(4);
    chk(status.stop_seen_flag, 1'h1);
    // Foreign address passes unnoticed
    pls(0);
    pls(1);
    m.start();
    xfer(8'h20, 1'h1);
    chk(status.port_irq_flag, 1'h0);
    m.stop();
    // Start interrupt from mode 2 and from the enable bit
    for (int k = 0; k < 2; k++)
    begin
      ctrl <= k ? 9'h040 : 9'h100;
      pls(0);
      m.start();
      hc(4);
      chk(status.port_irq_flag, 1'h1);
      m.stop();
    end
    // Software chooses the acknowledge, NACK first
    for (int v = 1; v >= 0; v--)
    begin
      ctrl <= {8'h0C, v[0]};
      pls(0);
      m.start();
      m.bits8(8'hA4);
      hc(4);
      chk(status.ack_time_flag, 1'h1);
      chk(clock_held, 1'h1);
      pls(1);
      pls(2);
      m.ack(a);
      chk(a, v[0]);
      m.stop();
    end
    // Stretch after a received byte until released
    ctrl <= 9'h004;
    pls(0);
    m.start();
    xfer(8'hA4, 1'h0);
    hc(2);
    chk(clock_held, 1'h1);
    pls(1);
    pls(2);
    chk(clock_held, 1'h0);
    m.stop();
    // 10-bit high and low address with update handshakes
    ctrl <= 9'h080;
    own_address_reg <= 8'h06;
    pls(0);
    m.start();
    xfer(8'hF6, 1'h0);
    hc(2);
    chk(status.address_update_flag, 1'h1);
    chk(clock_held, 1'h1);
    own_address_reg <= 8'h5A;
    pls(3);
    chk(status.address_update_flag, 1'h0);
    pls(1);
    xfer(8'h5A, 1'h0);
    hc(2);
    chk(status.address_update_flag, 1'h1);
    own_address_reg <= 8'h06;
    pls(3);
    // Restart as a read is taken only after the full match
    m.start();
    xfer(8'hF7, 1'h0);
    chk(status.rw_status, 1'h1);
    chk(rx_tx_buffer, 8'hF7);
    m.stop();
    pls(1);
    pls(0);
    m.start();
    xfer(8'hF7, 1'h1);
    chk(status.port_irq_flag, 1'h0);
    m.stop();
    // Fill the stalled FIFO past its depth, then drain it
    ctrl <= 9'h000;
    own_address_reg <= 8'hA5;
    pls(0);
    m.start();
    xfer(8'hA4, 1'h0);
    for (int i = 0; i < 34; i++)
    begin
      pls(1);
      m.bits8(8'(i));
      m.ack(a);
    end
    m.stop();
    fifo_ready <= 1'h1;
    cnt = 0;
    repeat (200)
    begin
      @(negedge sys_clk);
      if (fifo_valid && cnt == 0)
        chk(fifo_data, 8'hA4);
      cnt += fifo_valid;
    end
    chk(8'(cnt), 8'h20);
    chk(fifo_valid, 1'h0);
    end_sim();
  end
endmodule // testbench
